// >>> verilog/podc_top.sv
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
// Function
// R1: Two clock inputs and six clock and lock outputs toward user logic.
// R2: Three phase selectors, six programmable delays plus fixed one, five dividers.
// R3: One dynamic shift register reloads configuration while running.
// R4: Reference input feeds PLL core and primary output path.
// R5: In bypass, resync strobe resets final divider to align with input clock.
// R6: Resync strobe acts on its rising transition only.
// R7: User holds resync strobe low one divider input period before raising.
// R8: With PLL in use, strobe ignored; resync generated internally.
// R9: Half division only in bypass with RC oscillator driving reference.
// R10: Half division divides by 1.5 up to 14.5 in unit steps.
// R11: External feedback compared against reference in phase detector.
// R12: Active-low sleep disables PLL and forces all outputs low.
// R13: Active-high lock shows steady lock between reference and feedback.
// R14: Three global outputs from separate muxes with own selection and delay; code has a source select for A only, while B and C get only their own delays.
// R15: Two core clock outputs drive local routing, separate from globals.
// R16: Strobe edge detected on divider clock, count cleared next edge.
// R17: Half division requested outside its condition is ignored.
module podc_top
  import podc_pkg::*;
#(
  parameter int LOCK_COUNT = LOCK_COUNT_DEF
) (
  input  wire logic        I_CLK,                        // Divider input clock, 125 MHz
  input  wire logic        I_RST,                        // Synchronous reset, high
  input  wire logic        I_PSEL,                       // APB select
  input  wire logic        I_PENABLE,                    // APB enable
  input  wire logic        I_PWRITE,                     // APB write
  input  wire logic [7:0]  I_PADDR,                      // APB byte address
  input  wire logic [31:0] I_PWDATA,                     // APB write data
  output logic      [31:0] O_PRDATA,                     // APB read data
  output logic             O_PREADY,                     // APB ready
  output logic             O_PSLVERR,                    // APB error
  input  wire logic        I_REFERENCE_CLOCK_IN,         // Reference clock, sampled
  input  wire logic        I_EXTERNAL_FEEDBACK_IN,       // External feedback, sampled
  input  wire logic        I_DIVIDER_RESYNC_STROBE,      // Resync strobe, rising edge
  input  wire logic        I_HALF_DIVISION_CONTROL,      // Half division, high
  input  wire logic        I_PLL_SLEEP_N,                // Power down, low
  output logic             O_PRIMARY_GLOBAL_CLOCK,       // Global output A
  output logic             O_SECONDARY_GLOBAL_CLOCK_ONE, // Global output B
  output logic             O_SECONDARY_GLOBAL_CLOCK_TWO, // Global output C
  output logic             O_CORE_CLOCK_ONE,             // Local output B
  output logic             O_CORE_CLOCK_TWO,             // Local output C
  output logic             O_LOCK                        // Lock indicator
);

  // ==========================================================
  // Elaboration checks
  if (LOCK_COUNT < 1 || LOCK_COUNT > 255) begin : g_chk
    $error("LOCK_COUNT must lie in 1..255");
  end
  // Package sizing must cover the widest half-tick period and every tap
  if (CNT_W < DIV_W + 2) begin : g_chk_cnt
    $error("CNT_W too narrow for the divider period");
  end
  if (DLY_DEPTH != 2 ** TAP_W) begin : g_chk_dly
    $error("DLY_DEPTH must match the tap select width");
  end

  localparam logic [LOCK_W-1:0] LOCK_TARGET = LOCK_W'(LOCK_COUNT);

  // ==========================================================
  // Divider arithmetic
  // Counts half-ticks: integer d+1 takes 2(d+1), half d+1.5 takes 2d+3
  function automatic logic [CNT_W-1:0] period_of(input logic [DIV_W-1:0] d, input logic half);
    logic [CNT_W-1:0] base;
    base = CNT_W'({d, 1'b0}) + CNT_W'(2);
    return half ? base + CNT_W'(1) : base;
  endfunction

  function automatic logic [CNT_W-1:0] high_of(input logic [DIV_W-1:0] d, input logic half);
    logic [CNT_W-1:0] base;
    base = CNT_W'(d) + CNT_W'(1);
    return half ? base + CNT_W'(1) : base;
  endfunction

  // ==========================================================
  // Configuration, loaded only through the shift register
  logic [CFG_W-1:0] shadow_reg;
  logic [CFG_W-1:0] cfg_reg;
  logic             cfg_update;
  logic             apb_done;
  logic             apb_access;
  logic             wr_shift;
  logic             wr_ctrl;

  assign apb_access = I_PSEL & I_PENABLE & ~O_PREADY;
  assign apb_done   = I_PSEL & I_PENABLE & O_PREADY;
  assign wr_shift   = apb_done & I_PWRITE & (I_PADDR == ADDR_SHIFT_IN);
  assign wr_ctrl    = apb_done & I_PWRITE & (I_PADDR == ADDR_CTRL);
  assign cfg_update = wr_ctrl & I_PWDATA[CTRL_UPDATE_BIT];

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      shadow_reg <= CFG_RESET;
    end else if (wr_shift) begin
      shadow_reg <= {shadow_reg[CFG_W-2:0], I_PWDATA[0]}; // [R3]
    end
  end

  // Live reload; dividers B and C, and A outside bypass, resync on the same edge
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cfg_reg <= CFG_RESET;
    end else if (cfg_update) begin
      cfg_reg <= shadow_reg; // [R3]
    end
  end

  podc_src_t        src_sel;
  logic [DIV_W-1:0] n_div;
  logic [DIV_W-1:0] m_div;
  logic [DIV_W-1:0] u_div;
  logic             rc_ref;
  logic             ext_fb;
  logic             bypass;
  logic             a_on;
  logic             half_ok;
  logic             awake;

  assign src_sel = podc_src_t'(cfg_reg[SRC_LSB +: SRC_W]);
  assign n_div   = cfg_reg[REFDIV_LSB +: DIV_W];
  assign m_div   = cfg_reg[FBDIV_LSB +: DIV_W];
  assign rc_ref  = cfg_reg[RCREF_BIT];
  assign ext_fb  = cfg_reg[EXTERNAL_FEEDBACK_IN_BIT];
  assign bypass  = (src_sel == SRC_BYPASS);
  assign a_on    = (src_sel != SRC_OFF);
  assign awake   = I_PLL_SLEEP_N;
  assign half_ok = bypass & rc_ref & I_HALF_DIVISION_CONTROL; // [R9] [R17]
  // Half mode tops out at 14.5
  assign u_div   = (half_ok && cfg_reg[ADIV_LSB +: DIV_W] > HALF_DIV_MAX) ?
                   HALF_DIV_MAX : cfg_reg[ADIV_LSB +: DIV_W]; // [R10]

  // ==========================================================
  // Input edge detection
  logic ref_q_reg;
  logic ext_q_reg;
  logic strobe_q_reg;
  logic ref_rise;
  logic ref_edge;
  logic ext_rise;
  logic strobe_rise;

  // Strobe history resets high: a strobe held through reset is no edge
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ref_q_reg    <= 1'b0;
      ext_q_reg    <= 1'b0;
      strobe_q_reg <= 1'b1;
    end else begin
      ref_q_reg    <= I_REFERENCE_CLOCK_IN;
      ext_q_reg    <= I_EXTERNAL_FEEDBACK_IN;
      strobe_q_reg <= I_DIVIDER_RESYNC_STROBE;
    end
  end

  assign ref_rise    = I_REFERENCE_CLOCK_IN & ~ref_q_reg;
  assign ref_edge    = I_REFERENCE_CLOCK_IN ^ ref_q_reg; // [R4]
  assign ext_rise    = I_EXTERNAL_FEEDBACK_IN & ~ext_q_reg;
  assign strobe_rise = I_DIVIDER_RESYNC_STROBE & ~strobe_q_reg; // [R6] [R16]

  // ==========================================================
  // PLL core model: reference and feedback dividers, phase detector
  logic [DIV_W-1:0] refcnt_reg;
  logic [DIV_W-1:0] fbcnt_reg;
  logic [1:0]       fbseen_reg;
  logic [LOCK_W-1:0] lockcnt_reg;
  logic             lock_next;
  logic             ref_pulse;
  logic             fb_int_pulse;
  logic             fb_pulse;
  logic             int_resync;
  logic [DLY_DEPTH-1:0] line_reg [NUM_DLY];
  logic [NUM_DLY-1:0]   tap_out;

  assign ref_pulse    = awake & ref_rise & (refcnt_reg == n_div); // [R4]
  // Internal VCO ticks every cycle while awake
  assign fb_int_pulse = awake & (fbcnt_reg == m_div);
  assign fb_pulse     = awake & (ext_fb ? ext_rise : tap_out[5]); // [R11]

  always_ff @(posedge I_CLK) begin
    if (I_RST || !awake) begin
      refcnt_reg <= '0; // [R12]
    end else if (ref_rise) begin
      refcnt_reg <= (refcnt_reg >= n_div) ? '0 : refcnt_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST || !awake) begin
      fbcnt_reg <= '0;
    end else begin
      fbcnt_reg <= (fbcnt_reg >= m_div) ? '0 : fbcnt_reg + DIV_W'(1);
    end
  end

  // A feedback edge in the comparing cycle counts for the next window
  always_ff @(posedge I_CLK) begin
    if (I_RST || !awake) begin
      fbseen_reg <= 2'h0;
    end else if (ref_pulse) begin
      fbseen_reg <= {1'b0, fb_pulse}; // [R11]
    end else if (fb_pulse && fbseen_reg != 2'h2) begin
      fbseen_reg <= fbseen_reg + 2'h1;
    end
  end

  // Exactly one feedback edge per reference window counts as good
  always_ff @(posedge I_CLK) begin
    if (I_RST || !awake) begin
      lockcnt_reg <= '0;
    end else if (ref_pulse) begin
      if (fbseen_reg != 2'h1) begin
        lockcnt_reg <= '0; // [R13]
      end else if (lockcnt_reg != LOCK_TARGET) begin
        lockcnt_reg <= lockcnt_reg + LOCK_W'(1);
      end
    end
  end

  assign lock_next  = awake & (lockcnt_reg == LOCK_TARGET); // [R13]
  assign int_resync = (lock_next & ~O_LOCK) | cfg_update; // [R8]

  // ==========================================================
  // Output dividers A, B, C with phase selectors
  logic [CNT_W-1:0] cnt_reg [NUM_PH];
  logic [DIV_W-1:0] ch_div  [NUM_PH];
  logic [NUM_PH-1:0] ch_half;
  logic [NUM_PH-1:0] ch_tick;
  logic [NUM_PH-1:0] ch_sync;
  logic [NUM_PH-1:0] ch_bit;

  always_comb begin
    ch_div[0]  = u_div;
    ch_div[1]  = cfg_reg[BDIV_LSB +: DIV_W];
    ch_div[2]  = cfg_reg[CDIV_LSB +: DIV_W];
    ch_half    = {2'b00, half_ok}; // [R10]
    ch_tick    = {2'b11, bypass ? ref_edge : 1'b1}; // [R4]
    ch_sync[0] = bypass ? strobe_rise : int_resync; // [R5] [R8]
    ch_sync[1] = int_resync;
    ch_sync[2] = int_resync;
  end

  always_ff @(posedge I_CLK) begin
    for (int i = 0; i < NUM_PH; i++) begin
      if (I_RST || !awake) begin
        cnt_reg[i] <= '0;
      end else if (ch_sync[i]) begin
        cnt_reg[i] <= CNT_W'(cfg_reg[PH_LSB + i*PH_W +: PH_W]); // [R2] [R16]
      end else if (ch_tick[i]) begin
        cnt_reg[i] <= (cnt_reg[i] >= period_of(ch_div[i], ch_half[i]) - CNT_W'(1)) ?
                      '0 : cnt_reg[i] + CNT_W'(1); // [R2]
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PH; i++) begin
      ch_bit[i] = (cnt_reg[i] < high_of(ch_div[i], ch_half[i]));
    end
    ch_bit[0] = ch_bit[0] & a_on; // [R14]
  end

  // ==========================================================
  // Programmable delays: PRIMARY_GLOBAL_CLOCK, SECONDARY_GLOBAL_CLOCK_ONE, YB, SECONDARY_GLOBAL_CLOCK_TWO, YC, feedback
  logic [NUM_DLY-1:0] line_in;
  assign line_in = {fb_int_pulse, ch_bit[2], ch_bit[2], ch_bit[1], ch_bit[1], ch_bit[0]};

  always_ff @(posedge I_CLK) begin
    for (int k = 0; k < NUM_DLY; k++) begin
      if (I_RST || !awake) begin
        line_reg[k] <= '0;
      end else begin
        line_reg[k] <= {line_reg[k][DLY_DEPTH-2:0], line_in[k]}; // [R2]
      end
    end
  end

  always_comb begin
    for (int k = 0; k < NUM_DLY; k++) begin
      tap_out[k] = line_reg[k][cfg_reg[DLY_LSB + k*TAP_W +: TAP_W]]; // [R14]
    end
  end

  // ==========================================================
  // Output stage is the fixed delay; sleep forces everything low
  always_ff @(posedge I_CLK) begin
    if (I_RST || !awake) begin
      O_PRIMARY_GLOBAL_CLOCK       <= 1'b0; // [R12]
      O_SECONDARY_GLOBAL_CLOCK_ONE <= 1'b0;
      O_CORE_CLOCK_ONE             <= 1'b0;
      O_SECONDARY_GLOBAL_CLOCK_TWO <= 1'b0;
      O_CORE_CLOCK_TWO             <= 1'b0;
      O_LOCK                       <= 1'b0;
    end else begin
      O_PRIMARY_GLOBAL_CLOCK       <= tap_out[0]; // [R1] [R14]
      O_SECONDARY_GLOBAL_CLOCK_ONE <= tap_out[1]; // [R14]
      O_CORE_CLOCK_ONE             <= tap_out[2]; // [R15]
      O_SECONDARY_GLOBAL_CLOCK_TWO <= tap_out[3]; // [R14]
      O_CORE_CLOCK_TWO             <= tap_out[4]; // [R15]
      O_LOCK                       <= lock_next; // [R1] [R13]
    end
  end

  // ==========================================================
  // APB slave, one wait state
  // Writes to read-only offsets are dropped without an error
  logic [31:0] rdata;
  logic        addr_ok;

  always_comb begin
    rdata   = 32'h0;
    addr_ok = 1'b1;
    case (I_PADDR)
      ADDR_CTRL:     rdata = 32'h0;
      ADDR_SHIFT_IN: rdata = shadow_reg[31:0];
      ADDR_STATUS: begin
        rdata[ST_LOCK_BIT]   = O_LOCK;
        rdata[ST_AWAKE_BIT]  = awake;
        rdata[ST_BYPASS_BIT] = bypass;
        rdata[ST_HALF_BIT]   = half_ok;
      end
      ADDR_CFG_LO:   rdata = cfg_reg[31:0];
      ADDR_CFG_HI:   rdata = {10'h0, cfg_reg[CFG_W-1:32]};
      default:       addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= apb_access;
      O_PRDATA  <= (apb_access && !I_PWRITE) ? rdata : 32'h0;
      O_PSLVERR <= apb_access & ~addr_ok;
    end
  end

endmodule // podc_top

// >>> verilog/podc_pkg.sv
package podc_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_SHIFT_IN = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_CFG_LO   = 8'h0c;
  localparam logic [7:0] ADDR_CFG_HI   = 8'h10;

  localparam int CTRL_UPDATE_BIT = 0;
  localparam int ST_LOCK_BIT     = 0;
  localparam int ST_AWAKE_BIT    = 1;
  localparam int ST_BYPASS_BIT   = 2;
  localparam int ST_HALF_BIT     = 3;

  // ==========================================================
  // Configuration word layout
  localparam int CFG_W      = 54;
  localparam int SRC_LSB    = 0;
  localparam int SRC_W      = 3;
  localparam int DIV_W      = 5;
  localparam int REFDIV_LSB = 3;
  localparam int FBDIV_LSB  = 8;
  localparam int ADIV_LSB   = 13;
  localparam int BDIV_LSB   = 18;
  localparam int CDIV_LSB   = 23;
  localparam int NUM_DLY    = 6;
  localparam int TAP_W      = 3;
  localparam int DLY_LSB    = 28;
  localparam int NUM_PH     = 3;
  localparam int PH_W       = 2;
  localparam int PH_LSB     = 46;
  localparam int RCREF_BIT  = 52;
  localparam int EXTERNAL_FEEDBACK_IN_BIT  = 53;

  // ==========================================================
  // Source select encodings
  typedef enum logic [2:0] {
    SRC_OFF    = 3'h0,
    SRC_BYPASS = 3'h1,
    SRC_PLL    = 3'h2
  } podc_src_t;

  localparam logic [CFG_W-1:0] CFG_RESET = 54'h0 | 54'h2;

  // ==========================================================
  // Divider and delay sizing
  localparam int CNT_W     = 7;
  localparam int DLY_DEPTH = 8;
  localparam logic [DIV_W-1:0] HALF_DIV_MAX = 5'hd;
  localparam int LOCK_COUNT_DEF = 8;
  localparam int LOCK_W    = 8;

endpackage : podc_pkg

// >>> verif/podc_ref_model.sv
`timescale 1ns/10ps
// ==========================================
// Free-running reference clock source
module podc_ref_model #(
  parameter int HALF = 2
) (
  input  wire logic i_clk, // Sampling clock
  output logic      o_ref  // Reference clock
);
  int   cnt = 0;
  logic ref_reg = 1'b0;
  assign o_ref = ref_reg;
  // Reference runs free, also between tests
  always @(posedge i_clk) begin
    if (cnt == HALF - 1) begin
      ref_reg <= ~ref_reg;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // podc_ref_model

// >>> verif/podc_top_sva.sv
`timescale 1ns/10ps
module podc_top_sva (
  input wire logic        I_CLK,                        // Clock
  input wire logic        I_RST,                        // Reset
  input wire logic        I_PSEL,                       // Select
  input wire logic        I_PENABLE,                    // Enable
  input wire logic [31:0] O_PRDATA,                     // Read data
  input wire logic        O_PREADY,                     // Ready
  input wire logic        O_PSLVERR,                    // Error
  input wire logic        I_PLL_SLEEP_N,                // Sleep
  input wire logic        O_PRIMARY_GLOBAL_CLOCK,       // Out A
  input wire logic        O_SECONDARY_GLOBAL_CLOCK_ONE, // Out B
  input wire logic        O_SECONDARY_GLOBAL_CLOCK_TWO, // Out C
  input wire logic        O_CORE_CLOCK_ONE,             // Core B
  input wire logic        O_CORE_CLOCK_TWO,             // Core C
  input wire logic        O_LOCK                        // Lock
);
  // ==========================================
  // Register bus
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  AST_PREADY_WAIT: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
    else $error("ready not after one wait");
  AST_PREADY_PULSE: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  AST_RDATA_IDLE: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("read data outside answer");
  AST_SLVERR_READY: assert property (O_PSLVERR |-> O_PREADY && $past(I_PSEL))
    else $error("error without answer");
  AST_SLVERR_ZERO: assert property (O_PSLVERR |-> O_PRDATA == 32'h0)
    else $error("error with data");
  // ==========================================
  // Clock outputs
  AST_SLEEP_QUIET: assert property (!I_PLL_SLEEP_N |=>
    {O_PRIMARY_GLOBAL_CLOCK, O_SECONDARY_GLOBAL_CLOCK_ONE, O_SECONDARY_GLOBAL_CLOCK_TWO,
     O_CORE_CLOCK_ONE, O_CORE_CLOCK_TWO, O_LOCK} == 6'h0)
    else $error("outputs active in sleep");
  // Equal taps at reset, so core and global copies track
  AST_CORE_B: assert property (O_CORE_CLOCK_ONE == O_SECONDARY_GLOBAL_CLOCK_ONE)
    else $error("core one differs");
  AST_CORE_C: assert property (O_CORE_CLOCK_TWO == O_SECONDARY_GLOBAL_CLOCK_TWO)
    else $error("core two differs");
endmodule // podc_top_sva

bind podc_top podc_top_sva i_sva (.I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_PLL_SLEEP_N(I_PLL_SLEEP_N),
  .O_PRIMARY_GLOBAL_CLOCK(O_PRIMARY_GLOBAL_CLOCK), .O_SECONDARY_GLOBAL_CLOCK_ONE(O_SECONDARY_GLOBAL_CLOCK_ONE),
  .O_SECONDARY_GLOBAL_CLOCK_TWO(O_SECONDARY_GLOBAL_CLOCK_TWO), .O_CORE_CLOCK_ONE(O_CORE_CLOCK_ONE),
  .O_CORE_CLOCK_TWO(O_CORE_CLOCK_TWO), .O_LOCK(O_LOCK));

// >>> verif/testbench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
  import podc_pkg::*;
  logic        clk = 1'b0;
  logic        rst, psel, pen, pwr, strobe, half, sleep_n, refclk, pready, pslverr, e, pg, fb_en;
  logic        ga, gb, gc, yb, yc, lock;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [53:0] cfgs [3] = '{54'h10_0000_0001_a001, 54'h1_a001, 54'h10_0000_0001_a002};
  logic [31:0] exps [3] = '{32'hc, 32'h4, 32'h0};
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n;
  always #4 clk = ~clk;
  podc_ref_model #(.HALF(2)) i_ref (.i_clk(clk), .o_ref(refclk));
  podc_top #(.LOCK_COUNT(2)) i_dut (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_REFERENCE_CLOCK_IN(refclk), .I_EXTERNAL_FEEDBACK_IN(fb_en & refclk), .I_DIVIDER_RESYNC_STROBE(strobe),
    .I_HALF_DIVISION_CONTROL(half), .I_PLL_SLEEP_N(sleep_n), .O_PRIMARY_GLOBAL_CLOCK(ga),
    .O_SECONDARY_GLOBAL_CLOCK_ONE(gb), .O_SECONDARY_GLOBAL_CLOCK_TWO(gc), .O_CORE_CLOCK_ONE(yb),
    .O_CORE_CLOCK_TWO(yc), .O_LOCK(lock));
  // ==========================================
  // Tasks
  task close_out;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(q & m, x)
  endtask
  // Shadow shifts in at the LSB, so the top bit goes first
  task load(input logic [53:0] c);
    for (int i = 53; i >= 0; i--) apb(1'b1, ADDR_SHIFT_IN, {31'h0, c[i]});
    apb(1'b1, ADDR_CTRL, 32'h1);
  endtask
  // Cycles from the call until the next rising edge of output A
  task rise;
    n = 0;
    pg = ga;
    do begin
      @(posedge clk);
      n++;
      if (ga === 1'b1 && pg === 1'b0) break;
      pg = ga;
    end while (n < 500);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  // ==========================================
  // Tests
  initial begin
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    strobe = 1'b0; half = 1'b0; sleep_n = 1'b1; fb_en = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(ADDR_CFG_LO, 32'hffffffff, 32'h2);
    rdc(ADDR_CFG_HI, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    `CHK({e, q}, 33'h1_0000_0000)
    $display("test reset done");
    load(54'h302);
    rdc(ADDR_SHIFT_IN, 32'hffffffff, 32'h302);
    rdc(ADDR_CFG_LO, 32'hffffffff, 32'h302);
    n = 0;
    while (lock !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    `CHK(lock, 1'b1)
    rdc(ADDR_STATUS, 32'h7, 32'h3);
    $display("test lock done");
    // Divide by one with the core in use: A toggles every cycle
    strobe <= 1'b1;
    pg = ga;
    repeat (6) begin
      @(posedge clk);
      `CHK(ga, ~pg)
      `CHK({gb, gc}, {ga, ga})
      pg = ga;
    end
    strobe <= 1'b0;
    $display("test strobe done");
    sleep_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({ga, gb, gc, yb, yc, lock}, 6'h0)
    rdc(ADDR_STATUS, 32'h2, 32'h0);
    sleep_n <= 1'b1;
    $display("test sleep done");
    half <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      load(cfgs[i]);
      rdc(ADDR_STATUS, 32'hc, exps[i]);
    end
    load(cfgs[0]);
    rise();
    rise();
    `CHK(n, 58)
    half <= 1'b0;
    rise();
    rise();
    `CHK(n, 56)
    rdc(ADDR_STATUS, 32'hc, 32'h4);
    $display("test half done");
    // Bypass: a resync every 8 cycles keeps A high, as 14 half-ticks never pass
    load(cfgs[1]);
    repeat (9) begin
      strobe <= 1'b1;
      @(posedge clk);
      strobe <= 1'b0;
      repeat (7) @(posedge clk);
      `CHK(ga, 1'b1)
    end
    // A strobe held high resyncs once only, so A must fall again
    strobe <= 1'b1;
    n = 0;
    while (ga !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    `CHK(ga, 1'b0)
    strobe <= 1'b0;
    $display("test resync done");
    // External feedback chosen: internal m=3 would lock, a silent pin must not
    load(54'h20_0000_0000_0302);
    repeat (60) @(posedge clk);
    `CHK(lock, 1'b0)
    fb_en <= 1'b1;
    n = 0;
    while (lock !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    `CHK(lock, 1'b1)
    $display("test feedback done");
    close_out();
  end
endmodule // testbench
